// ---- hdl/fai_ctrl.sv ----
// Summary of operation
// [R1] power-up self-test runs; alarm and fault leds flash meanwhile
// [R2] failed self-test makes the fault led flash periodically
// [R3] remote indicator flashes at power-up, then mirrors the fault led
// [R4] conventional mode keeps all leds dark during power-up
// [R5] alarm led steady in alarm; off when cause clears if non-latching
// [R6] latching mode holds alarm indication until a reset
// [R7] alarm led stays off in pre-alarm without full alarm
// [R8] fault led flashes for hardware fault or dirty window
// [R9] conventional interface draws raised supply current in alarm
// [R10] current loop commanded to 17.0 mA in alarm
// [R11] alarm relay closed in alarm
// [R12] panel loop returns 190 in alarm
// [R13] status register readable; commands start tests or reset latches
// [R14] flashing centre overlay on video in alarm
// [R15] all alarm outputs follow cause, or hold until reset if latching
// [R16] pre-alarm entered when sub-threshold source seen
// [R17] relay stays open in pre-alarm
// [R18] current loop commanded to 11.5 mA in pre-alarm
// [R19] panel loop returns 153 in pre-alarm
// [R20] pre-alarm bit set in status register
// [R21] pre-alarm escalates to alarm or clears with the source; in latching mode the code holds it until a reset
// [R22] service mode flashes both leds together every 5 s
// [R23] alarm codes take priority over pre-alarm codes everywhere
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`include "fai_defs.svh"
`default_nettype none
module fai_ctrl
  import fai_pkg::*;
#(
  parameter int FLASH_CYC = `FAI_FLASH_MS * `FAI_CLK_MHZ * 1000,
  parameter int PERIOD_CYC = `FAI_PERIOD_MS * `FAI_CLK_MHZ * 1000,
  parameter int SVC_CYC = `FAI_SERVICE_S * `FAI_CLK_MHZ * 1000000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // detector states (asynchronous pins)
  input wire logic det_alarm,
  input wire logic det_prealarm,
  input wire logic det_hw_fault,
  input wire logic window_clean_fail,
  input wire logic selftest_done,
  input wire logic selftest_fail,
  input wire logic ext_reset,
  // indicators
  output logic alarm_led,
  output logic fault_led,
  output logic remote_ind,
  // interface outputs
  output logic conv_high_draw,
  output logic [7:0] loop_ma_x10,
  output logic relay_closed,
  output logic [7:0] panel_code,
  output logic video_overlay,
  // test requests
  output logic selftest_run,
  output logic window_test_req,
  output logic alarm_test_req
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int NIN = 7;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  logic [NIN-1:0] s3_reg;
  logic [NIN-1:0] pin_reg;
  assign pin_raw = {ext_reset, selftest_fail, selftest_done,
    window_clean_fail, det_hw_fault, det_prealarm, det_alarm};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
          pin_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          // a change counts only once two stages agree
          if (s2_reg[gi] == s3_reg[gi]) begin
            pin_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  logic in_alarm, in_pre, in_hwf, in_dirty;
  logic in_done, in_fail, in_rst;
  logic rst_pin_d_reg;
  assign in_alarm = pin_reg[0];
  assign in_pre = pin_reg[1];
  assign in_hwf = pin_reg[2];
  assign in_dirty = pin_reg[3];
  assign in_done = pin_reg[4];
  assign in_fail = pin_reg[5];
  assign in_rst = pin_reg[6];

  // ----------------------------------------
  // registers and bus
  // ----------------------------------------
  logic [3:0] ctrl_reg;
  logic [2:0] cmd_reg;
  logic aw_hold_reg;
  logic [3:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic [31:0] stat_word;
  logic [31:0] code_word;
  logic [31:0] rd_word;
  logic rd_ok;

  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      if (do_write) begin
        aw_hold_reg <= 1'b0;
      end else if (s_axi_awvalid && !aw_hold_reg && !s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= 1'b0;
      if (do_write) begin
        w_hold_reg <= 1'b0;
      end else if (s_axi_wvalid && !w_hold_reg && !s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FAI_RESP_OK;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_reg[1:0] == 2'h0) ? `FAI_RESP_OK : `FAI_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control word steers modes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_reg <= `FAI_CTRL_RST;
    end else if (do_write && aw_addr_reg == `FAI_OFS_CTRL && w_strb_reg[0]) begin
      ctrl_reg <= w_data_reg[3:0];
    end
  end

  // commands are one-cycle pulses, never stored
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmd_reg <= 3'h0;
    end else if (do_write && aw_addr_reg == `FAI_OFS_CMD && w_strb_reg[0]) begin
      cmd_reg <= w_data_reg[2:0]; // R13
    end else begin
      cmd_reg <= 3'h0;
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `FAI_OFS_CTRL: rd_word = {28'h0, ctrl_reg};
      `FAI_OFS_CMD: rd_word = 32'h0;
      `FAI_OFS_STAT: rd_word = stat_word; // R13
      `FAI_OFS_CODE: rd_word = code_word;
      default: begin
        rd_word = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `FAI_RESP_OK;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `FAI_RESP_OK : `FAI_RESP_ERR;
      end
    end
  end

  // ----------------------------------------
  // power-up sequence
  // ----------------------------------------
  fai_pu_t pu_reg;
  logic st_fail_reg;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pu_reg <= FAI_PU_TEST;
      st_fail_reg <= 1'b0;
    end else begin
      case (pu_reg)
        FAI_PU_TEST: begin
          if (in_done) begin
            pu_reg <= FAI_PU_RUN;
            st_fail_reg <= in_fail; // R2
          end
        end
        FAI_PU_RUN: pu_reg <= FAI_PU_RUN;
        default: pu_reg <= FAI_PU_TEST;
      endcase
    end
  end

  // ----------------------------------------
  // alarm and fault state
  // ----------------------------------------
  logic latch_mode, conv_mode, svc_mode, remote_on;
  logic clr_pulse;
  logic alm_lat_reg, pre_lat_reg, hwf_lat_reg, dirty_lat_reg;
  logic alm_act, pre_act, hwf_act, dirty_act, flt_act;
  assign latch_mode = ctrl_reg[`FAI_CTRL_LATCH];
  assign conv_mode = ctrl_reg[`FAI_CTRL_CONV];
  assign svc_mode = ctrl_reg[`FAI_CTRL_SERVICE];
  assign remote_on = ctrl_reg[`FAI_CTRL_REMOTE];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rst_pin_d_reg <= 1'b0;
    end else begin
      rst_pin_d_reg <= in_rst;
    end
  end
  assign clr_pulse = cmd_reg[`FAI_CMD_RESET] || (in_rst && !rst_pin_d_reg);

  // a live cause wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      alm_lat_reg <= 1'b0;
      pre_lat_reg <= 1'b0;
      hwf_lat_reg <= 1'b0;
      dirty_lat_reg <= 1'b0;
    end else begin
      alm_lat_reg <= in_alarm || (alm_lat_reg && !clr_pulse); // R6
      pre_lat_reg <= in_pre || (pre_lat_reg && !clr_pulse);
      hwf_lat_reg <= in_hwf || (hwf_lat_reg && !clr_pulse);
      dirty_lat_reg <= in_dirty || (dirty_lat_reg && !clr_pulse);
    end
  end

  assign alm_act = latch_mode ? alm_lat_reg : in_alarm; // R15
  // pre-alarm follows its source, or its latch in latching mode; alarm masks it
  assign pre_act = (latch_mode ? pre_lat_reg : in_pre) && !alm_act; // R16 R21 R23
  assign hwf_act = (latch_mode ? hwf_lat_reg : in_hwf) || st_fail_reg;
  assign dirty_act = latch_mode ? dirty_lat_reg : in_dirty;
  assign flt_act = hwf_act || dirty_act; // R8

  // ----------------------------------------
  // flash timing
  // ----------------------------------------
  logic [31:0] per_cnt_reg;
  logic [31:0] svc_cnt_reg;
  logic per_on, svc_on;

  always_ff @(posedge sys_clk) begin
    if (sys_rst || per_cnt_reg >= 32'(PERIOD_CYC - 1)) begin
      per_cnt_reg <= 32'h0;
    end else begin
      per_cnt_reg <= per_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !svc_mode || svc_cnt_reg >= 32'(SVC_CYC - 1)) begin
      svc_cnt_reg <= 32'h0;
    end else begin
      svc_cnt_reg <= svc_cnt_reg + 32'h1;
    end
  end

  // short flash at the start of each period
  assign per_on = per_cnt_reg < 32'(FLASH_CYC);
  assign svc_on = svc_mode && svc_cnt_reg < 32'(FLASH_CYC); // R22

  // ----------------------------------------
  // indicators
  // ----------------------------------------
  logic boot;
  assign boot = pu_reg == FAI_PU_TEST;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      alarm_led <= 1'b0;
      fault_led <= 1'b0;
      remote_ind <= 1'b0;
    end else if (boot) begin
      // dark in conventional mode to save loop power
      alarm_led <= per_on && !conv_mode; // R1 R4
      fault_led <= per_on && !conv_mode; // R1 R4
      remote_ind <= remote_on && per_on && !conv_mode; // R3
    end else if (svc_mode) begin
      alarm_led <= svc_on; // R22
      fault_led <= svc_on; // R22
      remote_ind <= remote_on && svc_on;
    end else begin
      alarm_led <= alm_act; // R5 R7
      fault_led <= flt_act && per_on; // R2 R8
      remote_ind <= remote_on && flt_act && per_on; // R3
    end
  end

  // ----------------------------------------
  // interface outputs
  // ----------------------------------------
  logic run;
  assign run = !boot && !svc_mode;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      conv_high_draw <= 1'b0;
      relay_closed <= 1'b0;
      video_overlay <= 1'b0;
      loop_ma_x10 <= `FAI_LOOP_NORM;
      panel_code <= `FAI_PANEL_NORM;
    end else begin
      conv_high_draw <= run && alm_act; // R9 R15
      relay_closed <= run && alm_act; // R11 R17
      video_overlay <= run && alm_act && per_on; // R14
      if (run && alm_act) begin
        loop_ma_x10 <= `FAI_LOOP_ALARM; // R10 R23
        panel_code <= `FAI_PANEL_ALARM; // R12 R23
      end else if (run && pre_act) begin
        loop_ma_x10 <= `FAI_LOOP_PRE; // R18
        panel_code <= `FAI_PANEL_PRE; // R19
      end else begin
        loop_ma_x10 <= `FAI_LOOP_NORM;
        panel_code <= `FAI_PANEL_NORM;
      end
    end
  end

  // ----------------------------------------
  // test requests and status
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      selftest_run <= 1'b1;
      window_test_req <= 1'b0;
      alarm_test_req <= 1'b0;
    end else begin
      selftest_run <= boot && !in_done; // R1
      // window test refused during alarm or pre-alarm
      window_test_req <= cmd_reg[`FAI_CMD_WINTEST] && !alm_act && !pre_act; // R13
      alarm_test_req <= cmd_reg[`FAI_CMD_ALMTEST]; // R13
    end
  end

  assign stat_word = {26'h0, st_fail_reg, boot, dirty_act, hwf_act,
    pre_act, alm_act}; // R20
  assign code_word = {16'h0, panel_code, loop_ma_x10};

endmodule
`default_nettype wire

// ---- hdl/fai_defs.svh ----
`ifndef FAI_DEFS_SVH
`define FAI_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FAI_OFS_CTRL 4'h0
`define FAI_OFS_CMD 4'h4
`define FAI_OFS_STAT 4'h8
`define FAI_OFS_CODE 4'hC
// ----------------------------------------
// control fields
// ----------------------------------------
`define FAI_CTRL_LATCH 0
`define FAI_CTRL_CONV 1
`define FAI_CTRL_SERVICE 2
`define FAI_CTRL_REMOTE 3
`define FAI_CTRL_RST 4'h0
// ----------------------------------------
// command fields (write one to act)
// ----------------------------------------
`define FAI_CMD_WINTEST 0
`define FAI_CMD_ALMTEST 1
`define FAI_CMD_RESET 2
// ----------------------------------------
// status fields
// ----------------------------------------
`define FAI_ST_ALARM 0
`define FAI_ST_PRE 1
`define FAI_ST_HWF 2
`define FAI_ST_DIRTY 3
`define FAI_ST_BUSY 4
`define FAI_ST_STFAIL 5
// ----------------------------------------
// interface codes
// ----------------------------------------
`define FAI_LOOP_ALARM 8'hAA
`define FAI_LOOP_PRE 8'h73
`define FAI_LOOP_NORM 8'h28
`define FAI_PANEL_ALARM 8'hBE
`define FAI_PANEL_PRE 8'h99
`define FAI_PANEL_NORM 8'h37
// ----------------------------------------
// timing
// ----------------------------------------
`define FAI_CLK_MHZ 100
`define FAI_FLASH_MS 250
`define FAI_PERIOD_MS 1000
`define FAI_SERVICE_S 5
`define FAI_RESP_OK 2'h0
`define FAI_RESP_ERR 2'h2
`endif

// ---- hdl/fai_pkg.sv ----
`default_nettype none
package fai_pkg;
  typedef enum logic [1:0] {
    FAI_PU_TEST,
    FAI_PU_RUN
  } fai_pu_t;
endpackage
`default_nettype wire

// ---- dv/fai_ctrl_chk.sv ----
`include "fai_defs.svh"
`default_nettype none
module fai_ctrl_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // detector side
  input wire logic det_alarm,
  input wire logic selftest_run,
  input wire logic selftest_done,
  // watched outputs
  input wire logic alarm_led,
  input wire logic conv_high_draw,
  input wire logic [7:0] loop_ma_x10,
  input wire logic relay_closed,
  input wire logic [7:0] panel_code,
  input wire logic window_test_req,
  input wire logic alarm_test_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ---
  // output relations
  // ---
  chk_alarm_codes:
  assert property (relay_closed |-> loop_ma_x10 == `FAI_LOOP_ALARM
    && panel_code == `FAI_PANEL_ALARM) else $error("alarm codes wrong");
  chk_alarm_draw:
  assert property (relay_closed |-> conv_high_draw && alarm_led) else $error("alarm out low");
  chk_pre_quiet:
  assert property (panel_code == `FAI_PANEL_PRE |-> !relay_closed
    && loop_ma_x10 == `FAI_LOOP_PRE) else $error("pre-alarm outputs wrong");
  chk_pre_led:
  assert property (panel_code == `FAI_PANEL_PRE && !selftest_run |-> !alarm_led)
    else $error("alarm led lit in pre-alarm");
  chk_alarm_clear:
  assert property ($fell(relay_closed) |-> !$past(det_alarm, 2))
    else $error("relay opened with alarm present");
  chk_selftest_hold:
  assert property (selftest_run && !selftest_done |=> selftest_run)
    else $error("self-test ended early");
  chk_wtest_pulse:
  assert property (window_test_req |=> !window_test_req) else $error("window pulse long");
  chk_atest_pulse:
  assert property (alarm_test_req |=> !alarm_test_req) else $error("alarm test pulse long");
  chk_bresp_hold:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_rdata_hold:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  cover property ($rose(relay_closed));
  cover property (panel_code == `FAI_PANEL_PRE);
  cover property (window_test_req);
endmodule
bind fai_ctrl fai_ctrl_chk u_chk (.*);
`default_nettype wire

// ---- dv/fai_front_model.sv ----
`default_nettype none
module fai_front_model #(
  parameter int ST_CYC = 60
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // from the controller
  input wire logic selftest_run,
  input wire logic window_test_req,
  // bench knobs
  input wire logic fail_mode,
  input wire logic dirty_mode,
  // detector results
  output logic selftest_done,
  output logic selftest_fail,
  output logic window_clean_fail
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // ---
  // self-test and window check engine
  // ---
  // slow answer on purpose; the fail line is junk until done rises
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt <= 0;
    end else if (selftest_run && cnt < ST_CYC) begin
      cnt <= cnt + 1;
    end
  end
  assign selftest_done = cnt == ST_CYC;
  assign selftest_fail = selftest_done ? fail_mode : cnt[0];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      window_clean_fail <= 1'h0;
    end else if (window_test_req) begin
      window_clean_fail <= dirty_mode;
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`include "fai_defs.svh"
`default_nettype none
module tb
  import fai_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ext_reset = 1'h0;
  logic det_alarm = 1'h0, det_prealarm = 1'h0, det_hw_fault = 1'h0;
  logic fail_mode = 1'h0, dirty_mode = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_d;
  logic alarm_led, fault_led, remote_ind, conv_high_draw, relay_closed, video_overlay;
  logic [7:0] loop_ma_x10, panel_code;
  logic selftest_done, selftest_fail, window_clean_fail, selftest_run;
  logic window_test_req, alarm_test_req, a, p;
  int num_errors = 0, total_checks = 0, wt_n = 0, at_n = 0;
  int seed = 32'hEDD027EB;
  wire logic [3:0] obs = {video_overlay, remote_ind, fault_led, alarm_led};
  fai_ctrl #(.FLASH_CYC(4), .PERIOD_CYC(16), .SVC_CYC(40)) dut (.*);
  fai_front_model #(.ST_CYC(60)) u_front (.*);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (window_test_req === 1'h1) wt_n <= wt_n + 1;
    if (alarm_test_req === 1'h1) at_n <= at_n + 1;
  end
  // ---
  // helpers
  // ---
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h1;
    @(posedge sys_clk);
    chk(s_axi_bresp, er, "bresp");
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [3:0] ad, output logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h1;
    @(posedge sys_clk);
    d = s_axi_rdata;
    chk(s_axi_rresp, er, "rresp");
    s_axi_rready <= 1'h0;
  endtask
  // want=1: all of m lit together once; want=0: none of m ever lit
  task seen(input logic [3:0] m, input int n, input logic want, input string s);
    logic ok;
    ok = 1'h0;
    repeat (n) begin
      @(posedge sys_clk);
      if (want ? (obs & m) == m : |(obs & m)) ok = 1'h1;
    end
    chk(ok, want, s);
  endtask
  function automatic logic [15:0] exp_codes(input logic al, input logic pr);
    if (al) return {`FAI_PANEL_ALARM, `FAI_LOOP_ALARM};
    if (pr) return {`FAI_PANEL_PRE, `FAI_LOOP_PRE};
    return {`FAI_PANEL_NORM, `FAI_LOOP_NORM};
  endfunction
  task give_verdict;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
  // ---
  // main sequence
  // ---
  initial begin
    idle(12);
    sys_rst <= 1'h0;
    chk(selftest_run, 1'h1, "st run");
    chk({panel_code, loop_ma_x10}, exp_codes(1'h0, 1'h0), "rst codes");
    wr(`FAI_OFS_CTRL, 32'h8, `FAI_RESP_OK);
    seen(4'h7, 20, 1'h1, "pu flash");
    while (selftest_run) @(posedge sys_clk);
    rd(`FAI_OFS_STAT, rd_d, `FAI_RESP_OK);
    chk(rd_d, 32'h0, "status");
    rd(4'h2, rd_d, `FAI_RESP_ERR);
    wr(4'h6, 32'h0, `FAI_RESP_ERR);
    for (int i = 0; i < 16; i++) begin
      {a, p} = i < 4 ? 2'(i) : 2'($random(seed));
      det_alarm <= a;
      det_prealarm <= p;
      idle(10);
      chk({panel_code, loop_ma_x10}, exp_codes(a, p), "codes");
      chk({relay_closed, conv_high_draw, alarm_led}, {3{a}}, "alarm out");
      rd(`FAI_OFS_CODE, rd_d, `FAI_RESP_OK);
      chk(rd_d[15:0], exp_codes(a, p), "code reg");
      rd(`FAI_OFS_STAT, rd_d, `FAI_RESP_OK);
      chk(rd_d[1:0], a ? 2'h1 : {p, 1'h0}, "stat bits");
    end
    det_alarm <= 1'h1;
    seen(4'h8, 40, 1'h1, "overlay");
    det_alarm <= 1'h0;
    det_prealarm <= 1'h0;
    idle(10);
    for (int k = 0; k < 2; k++) begin
      wr(`FAI_OFS_CTRL, 32'h9, `FAI_RESP_OK);
      det_alarm <= 1'h1;
      idle(10);
      det_alarm <= 1'h0;
      idle(10);
      chk(relay_closed & alarm_led, 1'h1, "latched");
      if (k == 0) wr(`FAI_OFS_CMD, 32'h4, `FAI_RESP_OK);
      else begin
        ext_reset <= 1'h1;
        idle(8);
        ext_reset <= 1'h0;
      end
      idle(10);
      chk({relay_closed, alarm_led}, 2'h0, "unlatched");
    end
    wr(`FAI_OFS_CTRL, 32'h8, `FAI_RESP_OK);
    dirty_mode <= 1'h1;
    wr(`FAI_OFS_CMD, 32'h1, `FAI_RESP_OK);
    seen(4'h6, 20, 1'h1, "dirty");
    rd(`FAI_OFS_STAT, rd_d, `FAI_RESP_OK);
    chk(rd_d[3], 1'h1, "dirty bit");
    dirty_mode <= 1'h0;
    wr(`FAI_OFS_CMD, 32'h1, `FAI_RESP_OK);
    idle(10);
    chk(wt_n, 32'h2, "wt pulses");
    det_prealarm <= 1'h1;
    idle(10);
    wr(`FAI_OFS_CMD, 32'h1, `FAI_RESP_OK);
    idle(4);
    chk(wt_n, 32'h2, "wt refused");
    det_prealarm <= 1'h0;
    det_hw_fault <= 1'h1;
    seen(4'h6, 20, 1'h1, "hw fault");
    det_hw_fault <= 1'h0;
    idle(20);
    seen(4'h2, 20, 1'h0, "fault off");
    wr(`FAI_OFS_CMD, 32'h2, `FAI_RESP_OK);
    idle(4);
    chk(at_n, 32'h1, "at pulse");
    wr(`FAI_OFS_CTRL, 32'h4, `FAI_RESP_OK);
    seen(4'h3, 50, 1'h1, "service");
    wr(`FAI_OFS_CTRL, 32'h0, `FAI_RESP_OK);
    fail_mode <= 1'h1;
    sys_rst <= 1'h1;
    idle(12);
    sys_rst <= 1'h0;
    wr(`FAI_OFS_CTRL, 32'h2, `FAI_RESP_OK);
    seen(4'h3, 30, 1'h0, "conv dark");
    while (selftest_run) @(posedge sys_clk);
    idle(4);
    rd(`FAI_OFS_STAT, rd_d, `FAI_RESP_OK);
    chk(rd_d[5:0], 6'h24, "st fail");
    wr(`FAI_OFS_CTRL, 32'h0, `FAI_RESP_OK);
    seen(4'h2, 40, 1'h1, "st fault");
    give_verdict();
  end
endmodule
`default_nettype wire
